/* design/wrap_timer_pkg.sv */
package wrap_timer_pkg;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_CLKCFG = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_WRAP = 4'hC;
   localparam int FLAG_BIT = 7;
   localparam int IRQEN_BIT = 6;
   localparam int CLEAR_BIT = 5;
   localparam int HALT_BIT = 4;
   localparam int SRC_LSB = 4;
   localparam int DIV_LSB = 0;
   localparam logic RST_IRQEN = 1'b0;
   localparam logic RST_HALT = 1'b1;
   localparam logic [1:0] RST_SRC = 2'h0;
   localparam logic [3:0] RST_DIV = 4'h0;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_WRAP = 8'h00;
   localparam logic [3:0] DIV_MAX = 4'h8;
   localparam int SYNC_STAGES = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SRC_BUS, SRC_FIXED, SRC_PIN_FALL, SRC_PIN_RISE
   } src_e;

   typedef struct packed {
      src_e src;
      logic [3:0] div;
   } clk_cfg_s;

   typedef struct packed {
      logic irq_en;
      logic halt;
   } ctrl_s;
endpackage

/* design/wrap_timer.sv */
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module wrap_timer (
   input wire logic clk, // bus clock, 250 MHz
   input wire logic rstn, // async reset, active low
   input wire logic ce, // clock enable, freezes all state when low
   input wire logic fixed_rate_clock, // fixed-rate clock, sampled
   input wire logic external_timer_pin, // external timer pin
   input wire logic [wrap_timer_pkg::ADDR_W-1:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // write strobes
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [wrap_timer_pkg::ADDR_W-1:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   output logic overflow_irq // overflow interrupt request
);
   import wrap_timer_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [7:0] wbyte_r;
   logic wlane_r;
   logic wr_fire, rd_fire;
   logic wr_status, wr_clkcfg, wr_wrap, wr_ok;
   logic rd_status, rd_ok;

   logic overflow_flag_r, arm_r, irq_r;
   ctrl_s ctrl_r;
   clk_cfg_s cfg_r;
   logic [7:0] count_r, count_nxt, wrap_r, limit;
   logic [7:0] presc_r, mask;
   logic [3:0] div_eff;
   logic src_tick, ps_tick, wrap_evt, zero_cnt, clear_req;

   logic [SYNC_STAGES-1:0] pin_sync_r, fix_sync_r;
   logic pin_lvl_r, fix_lvl_r, pin_rise, pin_fall, fix_rise;

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign overflow_irq = irq_r;

   ////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in any order, then one answer
   assign wr_fire = !awready_r && !wready_r && !bvalid_r;
   assign wr_ok = (aw_addr_r == OFS_STATUS) || (aw_addr_r == OFS_CLKCFG)
      || (aw_addr_r == OFS_COUNT) || (aw_addr_r == OFS_WRAP);
   assign wr_status = wr_fire && wlane_r && (aw_addr_r == OFS_STATUS);
   assign wr_clkcfg = wr_fire && wlane_r && (aw_addr_r == OFS_CLKCFG);
   assign wr_wrap = wr_fire && wlane_r && (aw_addr_r == OFS_WRAP);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         aw_addr_r <= '0;
         wbyte_r <= 8'h00;
         wlane_r <= 1'b0;
      end else if (ce) begin
         if (awvalid && awready_r) begin
            aw_addr_r <= awaddr;
            awready_r <= 1'b0;
         end
         if (wvalid && wready_r) begin
            wbyte_r <= wdata[7:0];
            wlane_r <= wstrb[0];
            wready_r <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read channel: data registered one cycle after the address is taken
   assign rd_fire = arvalid && arready_r;
   assign rd_status = rd_fire && (araddr == OFS_STATUS);
   assign rd_ok = (araddr == OFS_STATUS) || (araddr == OFS_CLKCFG)
      || (araddr == OFS_COUNT) || (araddr == OFS_WRAP);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (ce) begin
         if (rd_fire) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            case (araddr)
               OFS_STATUS: rdata_r <= {24'h000000, overflow_flag_r,
                  ctrl_r.irq_en, 1'b0, ctrl_r.halt, 4'h0};
               OFS_CLKCFG: rdata_r <= {24'h000000, 2'b00, cfg_r};
               OFS_COUNT: rdata_r <= {24'h000000, count_r};
               OFS_WRAP: rdata_r <= {24'h000000, wrap_r};
               default: rdata_r <= 32'h0000_0000;
            endcase
         end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control and configuration bits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r.irq_en <= RST_IRQEN;
         ctrl_r.halt <= RST_HALT;
      end else if (ce && wr_status) begin
         ctrl_r.irq_en <= wbyte_r[IRQEN_BIT];
         ctrl_r.halt <= wbyte_r[HALT_BIT];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_r.src <= src_e'(RST_SRC);
         cfg_r.div <= RST_DIV;
      end else if (ce && wr_clkcfg) begin
         // count and prescaler are left alone on a change
         cfg_r.src <= src_e'(wbyte_r[SRC_LSB+:2]);
         cfg_r.div <= wbyte_r[DIV_LSB+:4];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrap_r <= RST_WRAP;
      end else if (ce && wr_wrap) begin
         wrap_r <= wbyte_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers: a level counts once stages two and three agree
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_sync_r <= '0;
         fix_sync_r <= '0;
         pin_lvl_r <= 1'b0;
         fix_lvl_r <= 1'b0;
      end else if (ce) begin
         pin_sync_r <= {pin_sync_r[SYNC_STAGES-2:0],
            external_timer_pin};
         fix_sync_r <= {fix_sync_r[SYNC_STAGES-2:0], fixed_rate_clock};
         if (pin_sync_r[1] == pin_sync_r[2]) begin
            pin_lvl_r <= pin_sync_r[2];
         end
         if (fix_sync_r[1] == fix_sync_r[2]) begin
            fix_lvl_r <= fix_sync_r[2];
         end
      end
   end

   // one-cycle pulses on the filtered levels
   assign pin_rise = (pin_sync_r[1] == pin_sync_r[2])
      && pin_sync_r[2] && !pin_lvl_r;
   assign pin_fall = (pin_sync_r[1] == pin_sync_r[2])
      && !pin_sync_r[2] && pin_lvl_r;
   assign fix_rise = (fix_sync_r[1] == fix_sync_r[2])
      && fix_sync_r[2] && !fix_lvl_r;

   ////////////////////////////////////////////////////////////////////////
   // source selection and power-of-two prescaler
   always_comb begin
      case (cfg_r.src)
         SRC_BUS: src_tick = 1'b1;
         SRC_FIXED: src_tick = fix_rise;
         SRC_PIN_FALL: src_tick = pin_fall;
         SRC_PIN_RISE: src_tick = pin_rise;
         default: src_tick = 1'b1;
      endcase
   end

   assign div_eff = (cfg_r.div > DIV_MAX) ? DIV_MAX : cfg_r.div;
   assign mask = 8'((9'h001 << div_eff) - 9'h001);
   assign ps_tick = src_tick && !ctrl_r.halt
      && ((presc_r & mask) == mask);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         presc_r <= 8'h00;
      end else if (ce) begin
         if (zero_cnt) begin
            presc_r <= 8'h00;
         end else if (src_tick && !ctrl_r.halt) begin
            presc_r <= presc_r + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // main counter
   assign zero_cnt = (wr_status && wbyte_r[CLEAR_BIT]) || wr_wrap;
   assign limit = (wrap_r == 8'h00) ? 8'hFF : wrap_r;
   // a wrap in the cycle of a clear still sets the flag: the set wins
   assign wrap_evt = ps_tick && (count_r == limit);

   always_comb begin
      count_nxt = count_r;
      if (zero_cnt) begin
         count_nxt = 8'h00;
      end else if (ps_tick) begin
         count_nxt = (count_r == limit) ? 8'h00 : count_r + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_r <= RST_COUNT;
      end else if (ce) begin
         count_r <= count_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // overflow flag with two-step clear; a new overflow always wins
   assign clear_req = wr_status && !wbyte_r[FLAG_BIT] && arm_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         overflow_flag_r <= 1'b0;
      end else if (ce) begin
         if (wrap_evt) begin
            overflow_flag_r <= 1'b1;
         end else if (clear_req || zero_cnt) begin
            overflow_flag_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         arm_r <= 1'b0;
      end else if (ce) begin
         if (wrap_evt || wr_status || zero_cnt) begin
            arm_r <= 1'b0;
         end else if (rd_status && overflow_flag_r) begin
            arm_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_r <= 1'b0;
      end else if (ce) begin
         irq_r <= ctrl_r.irq_en && overflow_flag_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   flag_sets_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      wrap_evt |=> overflow_flag_r)
      else $error("overflow did not set the flag");
   no_read_clear_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      overflow_flag_r && !arm_r && !zero_cnt |=> overflow_flag_r)
      else $error("flag cleared without a prior status read");
   strobe_clear_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      zero_cnt && !wrap_evt |=> !overflow_flag_r && count_r == 8'h00)
      else $error("clear strobe or wrap write did not clear");
   irq_follows_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      ##1 overflow_irq == $past(ctrl_r.irq_en && overflow_flag_r))
      else $error("interrupt request does not follow enable and flag");
   halt_freezes_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      ctrl_r.halt && !zero_cnt |=> $stable(count_r))
      else $error("counter moved while halted");
   reset_defaults_a: assert property (@(posedge clk)
      $rose(rstn) |-> ctrl_r.halt && !ctrl_r.irq_en
         && cfg_r.div == RST_DIV && cfg_r.src == SRC_BUS)
      else $error("wrong values after reset");
   read_zero_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      rd_status |=> rdata_r[31:8] == 24'h000000
         && rdata_r[CLEAR_BIT] == 1'b0 && rdata_r[3:0] == 4'h0)
      else $error("unused or strobe bits read nonzero");
   cfg_zero_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      rd_fire && araddr == OFS_CLKCFG |=> rdata_r[31:6] == 26'h0000000)
      else $error("unused clock config bits read nonzero");
   div_rate_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      ps_tick && cfg_r.src == SRC_BUS && cfg_r.div == 4'h1 && !zero_cnt
      ##1 (cfg_r.div == 4'h1 && !ctrl_r.halt && !zero_cnt)
      |-> !ps_tick)
      else $error("divide-by-two ticked twice in a row");
   big_div_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      cfg_r.div > DIV_MAX |-> mask == 8'hFF)
      else $error("large divider code not clipped to 256");
   wrap_zero_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      wrap_evt |=> count_r == 8'h00)
      else $error("counter did not wrap to zero");
   abandon_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      wrap_evt |=> !arm_r)
      else $error("overflow did not abandon the clear sequence");
   arm_clear_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      clear_req && !wrap_evt |=> !overflow_flag_r)
      else $error("armed zero write did not clear the flag");
   pin_pulse_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      pin_rise |=> !pin_rise)
      else $error("pin edge pulse longer than one cycle");
   count_step_a: assert property (@(posedge clk) disable iff (!rstn || !ce)
      !ps_tick && !zero_cnt |=> $stable(count_r))
      else $error("counter moved without a prescaler pulse");

   overflow_c: cover property (@(posedge clk) disable iff (!rstn)
      wrap_evt && wrap_r != 8'h00);
   free_run_c: cover property (@(posedge clk) disable iff (!rstn)
      wrap_evt && wrap_r == 8'h00);
   two_step_c: cover property (@(posedge clk) disable iff (!rstn)
      clear_req && overflow_flag_r);
   pin_count_c: cover property (@(posedge clk) disable iff (!rstn)
      ps_tick && cfg_r.src == SRC_PIN_FALL);
   abandon_c: cover property (@(posedge clk) disable iff (!rstn)
      arm_r && wrap_evt);
endmodule

/* sim/testbench.sv */
`timescale 1ns/100ps
module testbench;
   import wrap_timer_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic fixed_rate_clock = 1'b0;
   logic external_timer_pin = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [ADDR_W-1:0] araddr = '0;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   logic overflow_irq;
   logic [3:0] slow_cnt = '0;
   int bad_count = 0;
   int checked = 0;
   logic [31:0] v;
   logic [31:0] v2;
   logic [1:0] r;

   always #2 clk = ~clk;

   wrap_timer u_dut (
      .clk(clk), .rstn(rstn), .ce(ce),
      .fixed_rate_clock(fixed_rate_clock),
      .external_timer_pin(external_timer_pin),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .overflow_irq(overflow_irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // slow sources: period of 16 bus cycles, well under a quarter rate
   always @(posedge clk) begin
      slow_cnt <= slow_cnt + 4'h1;
      fixed_rate_clock <= slow_cnt[3];
      external_timer_pin <= slow_cnt[3];
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic inr(input logic [31:0] x, input int lo, input int hi);
      chk(32'((x >= 32'(lo)) && (x <= 32'(hi))), 32'h1);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d,
                     output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h0, d};
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 100);
      resp = bresp;
      bready <= 1'b0;
      if (n >= 100) chk(32'h0, 32'h1);
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 100);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n >= 100) chk(32'h0, 32'h1);
   endtask

   // run from zero for win cycles with the given source and divider
   task automatic measure(input logic [1:0] s, input logic [3:0] d,
                          input int win, output logic [31:0] c);
      logic [1:0] q;
      wr(OFS_STATUS, 8'h30, q);
      wr(OFS_CLKCFG, {2'b00, s, d}, q);
      wr(OFS_WRAP, 8'h00, q);
      wr(OFS_STATUS, 8'h00, q);
      repeat (win) @(posedge clk);
      wr(OFS_STATUS, 8'h10, q);
      rd(OFS_COUNT, c, q);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge clk);
      bad_count++;
      results();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk({31'h0, overflow_irq}, 32'h0);
      rd(OFS_STATUS, v, r); chk(v, 32'h10);
      rd(OFS_CLKCFG, v, r); chk(v, 32'h00);
      rd(OFS_COUNT, v, r); chk(v, 32'h00);
      wr(OFS_CLKCFG, 8'hFF, r);
      rd(OFS_CLKCFG, v, r); chk(v, 32'h3F);
      wr(4'h2, 8'hFF, r); chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd(4'h2, v, r); chk({30'h0, r}, {30'h0, RESP_SLVERR});
      chk(v, 32'h0);
      // modulo count with flag, then the two-step clear
      wr(OFS_CLKCFG, 8'h00, r);
      wr(OFS_WRAP, 8'h04, r);
      wr(OFS_STATUS, 8'h00, r);
      repeat (30) @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         rd(OFS_COUNT, v, r); inr(v, 0, 4);
      end
      wr(OFS_STATUS, 8'h90, r);
      rd(OFS_STATUS, v, r); chk(v, 32'h90);
      wr(OFS_STATUS, 8'h90, r);
      wr(OFS_STATUS, 8'h10, r);
      rd(OFS_STATUS, v, r); chk(v, 32'h90);
      wr(OFS_STATUS, 8'h10, r);
      rd(OFS_STATUS, v, r); chk(v, 32'h10);
      // halted count holds
      rd(OFS_COUNT, v, r);
      repeat (20) @(posedge clk);
      rd(OFS_COUNT, v2, r); chk(v2, v);
      // overflow between read and zero write keeps the flag
      wr(OFS_WRAP, 8'h01, r);
      wr(OFS_STATUS, 8'h00, r);
      repeat (10) @(posedge clk);
      rd(OFS_STATUS, v, r); chk(v, 32'h80);
      repeat (20) @(posedge clk);
      wr(OFS_STATUS, 8'h10, r);
      rd(OFS_STATUS, v, r); chk(v, 32'h90);
      wr(OFS_WRAP, 8'h03, r);
      rd(OFS_STATUS, v, r); chk(v, 32'h10);
      rd(OFS_COUNT, v, r); chk(v, 32'h00);
      // interrupt: raised only with the flag set
      wr(OFS_STATUS, 8'h50, r);
      repeat (2) @(posedge clk);
      chk({31'h0, overflow_irq}, 32'h0);
      wr(OFS_STATUS, 8'h40, r);
      repeat (20) @(posedge clk);
      chk({31'h0, overflow_irq}, 32'h1);
      // slow the count so that no overflow meets the strobe below
      wr(OFS_CLKCFG, 8'h08, r);
      repeat (2) @(posedge clk);
      chk({31'h0, overflow_irq}, 32'h1);
      wr(OFS_STATUS, 8'h30, r);
      rd(OFS_COUNT, v, r); chk(v, 32'h00);
      rd(OFS_STATUS, v, r); chk(v, 32'h10);
      repeat (2) @(posedge clk);
      chk({31'h0, overflow_irq}, 32'h0);
      wr(OFS_STATUS, 8'h10, r);
      // every divider code on the bus clock, free-running
      for (int d = 0; d < 16; d++) begin
         measure(2'b00, 4'(d), 20 << ((d > 8) ? 8 : d), v);
         inr(v, 20, 24);
      end
      // free run past the top of the range
      measure(2'b00, 4'h0, 256, v); inr(v, 3, 5);
      rd(OFS_STATUS, v, r); chk(v, 32'h90);
      // slow sources at divide by one
      for (int s = 1; s < 4; s++) begin
         measure(2'(s), 4'h0, 320, v);
         inr(v, 19, 22);
      end
      // source and divider change in mid-run keep the count
      measure(2'b00, 4'h0, 0, v);
      wr(OFS_STATUS, 8'h00, r);
      repeat (60) @(posedge clk);
      wr(OFS_CLKCFG, 8'h11, r);
      rd(OFS_COUNT, v, r); inr(v, 60, 90);
      repeat (64) @(posedge clk);
      rd(OFS_COUNT, v2, r); inr(v2, 32'(v) + 1, 32'(v) + 6);
      // a low clock enable freezes the running count
      wr(OFS_CLKCFG, 8'h00, r);
      rd(OFS_COUNT, v, r);
      ce <= 1'b0;
      repeat (40) @(posedge clk);
      ce <= 1'b1;
      rd(OFS_COUNT, v2, r); inr(v2, 32'(v) + 1, 32'(v) + 8);
      wr(OFS_STATUS, 8'h10, r);
      results();
   end
endmodule
